// file: rtl/flash_ctrl_defines.svh
// constants for the flash command and read control block
// Notes on behaviour
// RULE_01: eleven erase blocks: 16K, 8K, 8K, 32K, then seven 64K segments.
// RULE_02: array reads return a 32-bit word with no wait states.
// RULE_03: reads are double-word aligned; address bits 1 and 0 are ignored.
// RULE_04: the three top address bits pick the 64K segment read.
// RULE_05: operations start only after the final command write decodes.
// RULE_06: pauses allowed between command writes except erase confirms.
// RULE_07: host sends every erase confirm before the 96 us time-out ends.
// RULE_08: any wrong write, address or data order returns to read mode.
// RULE_09: six-write erase sequence; each extra confirm adds a block.
// RULE_10: after the last confirm wait 96 us, then erase unaided.
// RULE_11: erased words read all ones; no pre-programming needed.
// RULE_12: a running erase can be suspended, then resumed.
// RULE_13: during an operation reads return a status word.
// RULE_14: a locked block refuses program and erase.
// RULE_15: locks lift only temporarily, for updates; the lock itself stays.
// RULE_16: read protection blocks data reads not fetched from flash.
// RULE_17: write protection stays in force during boot.
// RULE_18: finished operations fall back to read mode by themselves. The code keeps failed ones in ST_FAIL until an f0 write or a cpu reset.
// RULE_19: no reads during power-on setup; cpu held in reset meanwhile. The code holds it only while external_access_pin_n_i is high.
// RULE_20: read mode after power-on, reset, cpu reset, bad protected write.
// RULE_21: read mode holds until a command starts an array operation.
// RULE_22: host writes commands from code running outside the flash.
// RULE_23: commands open with a8 at 1554h, 54 at 2aa8h; f0 resets.
// RULE_24: program: unlock, a0 at 1554h, then address and data.
// RULE_25: erase: unlock, 80, unlock, 30 in block; confirms restart time-out.
// RULE_26: status bits: 7 polling, 6 toggle, 5 error, 3 erase time-out.
`ifndef FLASH_CTRL_DEFINES_SVH
`define FLASH_CTRL_DEFINES_SVH

`define FLASH_ADDR_W      19
`define FLASH_BLOCKS      11
`define UNLOCK_ADDR1      16'h1554
`define UNLOCK_ADDR2      16'h2aa8
`define CODE_UNLOCK1      8'ha8
`define CODE_UNLOCK2      8'h54
`define CODE_RESET        8'hf0
`define CODE_PROGRAM      8'ha0
`define CODE_ERASE        8'h80
`define CODE_CONFIRM      8'h30
`define CODE_SUSPEND      8'hb0
`define CODE_RESUME       8'h30
`define CODE_BLK_PROT     8'hc0
`define CODE_BLK_UNPROT   8'hc1
`define CODE_CODE_PROT    8'hc2
`define CODE_CODE_UNPROT  8'hc3
`define READ_PROT_WORD    32'h009b009b
`define ERASED_WORD       32'hffffffff
`define STAT_POLL_BIT     7
`define STAT_TOGGLE_BIT   6
`define STAT_ERROR_BIT    5
`define STAT_ETO_BIT      3
`define STAT_TOGGLE2_BIT  2
`define CLK_PERIOD_NS     50
`define ERASE_TO_NS       96000
`define ERASE_TO_CYC      ((`ERASE_TO_NS + `CLK_PERIOD_NS - 1)/`CLK_PERIOD_NS)
`define PROGRAM_NS        16000
`define PROGRAM_CYC       ((`PROGRAM_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETUP_NS          20000
`define SETUP_CYC         ((`SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CPU_RST_NS        2000
`define CPU_RST_CYC       ((`CPU_RST_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ERASE_MS          1500
`define ERASE_CYC_DEF     (`ERASE_MS * 1000000 / `CLK_PERIOD_NS)

`endif

// file: rtl/flash_ctrl_pkg.sv
// types for the flash command and read control block
package flash_ctrl_pkg;

   typedef enum logic [6:0] {
      ST_SETUP = 7'b0000001,
      ST_READ  = 7'b0000010,
      ST_PROG  = 7'b0000100,
      ST_EWAIT = 7'b0001000,
      ST_ERASE = 7'b0010000,
      ST_SUSP  = 7'b0100000,
      ST_FAIL  = 7'b1000000
   } mode_t;

   typedef enum logic [7:0] {
      C_IDLE = 8'b00000001,
      C_U1   = 8'b00000010,
      C_U2   = 8'b00000100,
      C_PW   = 8'b00001000,
      C_ER1  = 8'b00010000,
      C_ER2  = 8'b00100000,
      C_ER3  = 8'b01000000,
      C_PR   = 8'b10000000
   } cmd_step_t;

   typedef enum logic [4:0] {
      OP_WORD   = 5'b00001,
      OP_BPROT  = 5'b00010,
      OP_BUNP   = 5'b00100,
      OP_CPROT  = 5'b01000,
      OP_CUNP   = 5'b10000
   } op_t;

endpackage

// file: rtl/flash_ctrl.sv
// flash array, command interface and erase/program controller
`timescale 1ns/1ns
`include "flash_ctrl_defines.svh"

module flash_ctrl
   import flash_ctrl_pkg::*;
#(
   parameter logic [31:0] ERASE_CYC = `ERASE_CYC_DEF
) (
   input  wire logic                      clk_sys_i,
   input  wire logic                      rst_i,
   input  wire logic [`FLASH_ADDR_W-1:0]  addr_i,
   input  wire logic [15:0]               wdata_i,
   input  wire logic                      wr_i,
   input  wire logic                      rd_i,
   input  wire logic                      fetch_i,
   output logic      [31:0]               rdata_o,
   input  wire logic                      external_access_pin_n_i,
   input  wire logic                      cpu_reset_n_i,
   output logic                           cpu_hold_o,
   output logic                           busy_o,
   output logic      [`FLASH_BLOCKS-1:0]  block_lock_o,
   output logic                           code_prot_o
);

   localparam int AW    = `FLASH_ADDR_W;
   localparam int WORDS = 1 << (AW - 2);
   localparam int NB    = `FLASH_BLOCKS;
   logic [31:0]    mem [0:WORDS-1];
   mode_t          state_r;
   cmd_step_t      step_r;
   op_t            op_r;
   logic [31:0]    cnt_r;
   logic [NB-1:0]  emask_r;
   logic [NB-1:0]  lock_r;
   logic [NB-1:0]  unlock_r;
   logic           cprot_r;
   logic           cunp_r;
   logic           err_r;
   logic           susp_r;
   logic           toggle_r;
   logic [AW-3:0]  prog_idx_r;
   logic [31:0]    prog_word_r;
   logic           prog_b7_r;
   logic [3:0]     op_blk_r;
   logic [AW-3:0]  sweep_r;
   logic           sweep_done_r;
   logic [1:0]     ea_sync_r;
   logic [1:0]     crst_sync_r;
   logic [15:0]    setup_cnt_r;
   logic [15:0]    crst_cnt_r;
   logic           crst_fire;
   logic [7:0]     wd;
   logic [15:0]    wa;
   logic [3:0]     wblk;
   logic [AW-3:0]  widx;
   logic [31:0]    old_word;
   logic [31:0]    new_word;
   logic           prog_bad;
   logic           rprot_on;
   logic           blk_locked;
   logic           status_rd;
   logic [15:0]    status;
   // map a byte address to its erase block
   function automatic logic [3:0] block_of(input logic [AW-1:0] a);
      logic [3:0] b;
      b = 4'h0;
      if (a[18:16] != 3'h0) begin
         b = {1'b0, a[18:16]} + 4'h3;                 // RULE_01
      end else if (a[15]) begin
         b = 4'h3;
      end else if (a[14]) begin
         b = a[13] ? 4'h2 : 4'h1;
      end
      return b;
   endfunction
   // pin inputs pass two flops before any use
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         ea_sync_r   <= 2'b00;
         crst_sync_r <= 2'b11;
      end else begin
         ea_sync_r   <= {ea_sync_r[0], external_access_pin_n_i};
         crst_sync_r <= {crst_sync_r[0], cpu_reset_n_i};
      end
   end

   // cpu reset must last a few microseconds before the flash reacts
   always_ff @(posedge clk_sys_i) begin
      if (rst_i || crst_sync_r[1]) begin
         crst_cnt_r <= 16'h0000;
      end else if (crst_cnt_r != 16'(`CPU_RST_CYC)) begin
         crst_cnt_r <= crst_cnt_r + 16'h0001;
      end
   end
   assign crst_fire = (crst_cnt_r == 16'(`CPU_RST_CYC - 1)); // RULE_20
   // power-on setup delay
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         setup_cnt_r <= 16'h0000;
      end else if (state_r == ST_SETUP) begin
         setup_cnt_r <= setup_cnt_r + 16'h0001;
      end
   end

   // write decode helpers; only the low data byte carries a command
   assign wd       = wdata_i[7:0];
   assign wa       = addr_i[15:0];
   assign wblk     = block_of(addr_i);
   assign widx     = addr_i[AW-1:2];
   assign old_word = mem[widx];
   assign new_word = addr_i[1] ? {wdata_i, old_word[15:0]}
                               : {old_word[31:16], wdata_i};
   // a one over a programmed zero cannot be written
   assign prog_bad = ((~old_word) & new_word) != 32'h0;   // RULE_24
   assign rprot_on = cprot_r && !cunp_r;
   // locks hold in every mode, boot included; only temporary unlock helps
   assign blk_locked = lock_r[wblk] && !unlock_r[wblk];   // RULE_14 RULE_17

   // mode machine and command interface
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         state_r      <= ST_SETUP;
         step_r       <= C_IDLE;
         op_r         <= OP_WORD;
         cnt_r        <= 32'h0;
         emask_r      <= '0;
         lock_r       <= '0;
         unlock_r     <= '0;
         cprot_r      <= 1'b0;
         cunp_r       <= 1'b0;
         err_r        <= 1'b0;
         susp_r       <= 1'b0;
         prog_idx_r   <= '0;
         prog_word_r  <= 32'h0;
         prog_b7_r    <= 1'b0;
         op_blk_r     <= 4'h0;
         sweep_r      <= '0;
         sweep_done_r <= 1'b0;
      end else if (crst_fire && state_r != ST_SETUP) begin
         state_r  <= ST_READ;                          // RULE_20
         step_r   <= C_IDLE;
         emask_r  <= '0;
         err_r    <= 1'b0;
         susp_r   <= 1'b0;
         unlock_r <= '0;
         cunp_r   <= 1'b0;
      end else begin
         unique case (state_r)
            ST_SETUP: begin
               if (setup_cnt_r == 16'(`SETUP_CYC - 1)) begin
                  state_r <= ST_READ;                  // RULE_19
               end
            end
            ST_READ, ST_SUSP: begin
               // nothing runs until the last write decodes
               if (wr_i) begin                 // RULE_05 RULE_06 RULE_21
                  step_r <= C_IDLE;                    // RULE_08
                  if (wd == `CODE_RESET) begin
                     step_r <= C_IDLE;                 // RULE_23
                  end else if (state_r == ST_SUSP && step_r == C_IDLE &&
                               wd == `CODE_RESUME) begin
                     state_r <= ST_ERASE;              // RULE_12
                  end else begin
                     unique case (step_r)
                        C_IDLE: begin
                           if (wa == `UNLOCK_ADDR1 &&
                               wd == `CODE_UNLOCK1) begin
                              step_r <= C_U1;          // RULE_23
                           end
                        end
                        C_U1: begin
                           if (wa == `UNLOCK_ADDR2 &&
                               wd == `CODE_UNLOCK2) begin
                              step_r <= C_U2;
                           end
                        end
                        C_U2: begin
                           if (wa == `UNLOCK_ADDR1) begin
                              step_r <= C_PR;
                              unique case (wd)
                                 `CODE_PROGRAM:    step_r <= C_PW;
                                 `CODE_ERASE:      step_r <= (state_r ==
                                    ST_SUSP) ? C_IDLE : C_ER1;
                                 `CODE_BLK_PROT:   op_r <= OP_BPROT;
                                 `CODE_BLK_UNPROT: op_r <= OP_BUNP;
                                 `CODE_CODE_PROT:  op_r <= OP_CPROT;
                                 `CODE_CODE_UNPROT: op_r <= OP_CUNP;
                                 default:          step_r <= C_IDLE;
                              endcase
                           end
                        end
                        C_PW: begin
                           // bad protected write drops back to read mode
                           if (rprot_on || blk_locked ||
                               (susp_r && emask_r[wblk])) begin
                              step_r <= C_IDLE;        // RULE_14 RULE_20
                           end else begin
                              op_r        <= OP_WORD;  // RULE_24
                              prog_idx_r  <= widx;
                              prog_word_r <= new_word & old_word;
                              prog_b7_r   <= wdata_i[7];
                              err_r       <= prog_bad;
                              susp_r      <= (state_r == ST_SUSP);
                              cnt_r       <= 32'h0;
                              state_r     <= ST_PROG;
                           end
                        end
                        C_ER1: begin
                           if (wa == `UNLOCK_ADDR1 &&
                               wd == `CODE_UNLOCK1) begin
                              step_r <= C_ER2;
                           end
                        end
                        C_ER2: begin
                           if (wa == `UNLOCK_ADDR2 &&
                               wd == `CODE_UNLOCK2) begin
                              step_r <= C_ER3;
                           end
                        end
                        C_ER3: begin
                           if (wd == `CODE_CONFIRM) begin
                              // locked blocks are left out of the erase
                              emask_r[wblk] <= !blk_locked; // RULE_09
                              cnt_r         <= 32'h0;
                              state_r       <= ST_EWAIT;
                           end
                        end
                        C_PR: begin
                           if (wd == `CODE_BLK_PROT ||
                               wd == `CODE_BLK_UNPROT ||
                               wd == `CODE_CODE_PROT ||
                               wd == `CODE_CODE_UNPROT) begin
                              op_blk_r <= wblk;
                              susp_r   <= (state_r == ST_SUSP);
                              cnt_r    <= 32'h0;
                              err_r    <= 1'b0;
                              state_r  <= ST_PROG;     // RULE_21
                           end
                        end
                        default: step_r <= C_IDLE;
                     endcase
                  end
               end
            end
            ST_PROG: begin
               cnt_r <= cnt_r + 32'h1;
               if (cnt_r == 32'(`PROGRAM_CYC - 1)) begin
                  unique case (op_r)
                     OP_BPROT: lock_r[op_blk_r]   <= 1'b1; // RULE_14
                     OP_BUNP:  unlock_r[op_blk_r] <= 1'b1; // RULE_15
                     OP_CPROT: cprot_r            <= 1'b1; // RULE_16
                     OP_CUNP:  cunp_r             <= 1'b1; // RULE_16
                     default: ;
                  endcase
                  step_r  <= C_IDLE;
                  // an error waits for a reset write
                  state_r <= err_r ? ST_FAIL
                                   : (susp_r ? ST_SUSP : ST_READ); // RULE_18
               end
            end
            ST_EWAIT: begin
               cnt_r <= cnt_r + 32'h1;
               if (wr_i) begin
                  // only further confirms may arrive here
                  if (wd == `CODE_CONFIRM) begin       // RULE_25
                     emask_r[wblk] <= !blk_locked;
                     cnt_r         <= 32'h0;
                  end else begin
                     emask_r <= '0;                    // RULE_08
                     step_r  <= C_IDLE;
                     state_r <= ST_READ;
                  end
               end else if (cnt_r == 32'(`ERASE_TO_CYC - 1)) begin
                  cnt_r        <= 32'h0;               // RULE_10
                  sweep_r      <= '0;
                  sweep_done_r <= 1'b0;
                  step_r       <= C_IDLE;
                  susp_r       <= 1'b0;
                  if (emask_r == '0) begin
                     err_r   <= 1'b1;
                     state_r <= ST_FAIL;
                  end else begin
                     state_r <= ST_ERASE;
                  end
               end
            end
            ST_ERASE: begin
               if (wr_i && wd == `CODE_SUSPEND) begin
                  state_r <= ST_SUSP;                  // RULE_12
                  step_r  <= C_IDLE;
               end else begin
                  if (cnt_r != ERASE_CYC) begin
                     cnt_r <= cnt_r + 32'h1;
                  end
                  if (!sweep_done_r) begin
                     sweep_r      <= sweep_r + 1'b1;
                     sweep_done_r <= (sweep_r == '1);
                  end
                  if (cnt_r >= ERASE_CYC - 32'h1 && sweep_done_r) begin
                     emask_r <= '0;
                     state_r <= ST_READ;               // RULE_18
                  end
               end
            end
            ST_FAIL: begin
               if (wr_i && wd == `CODE_RESET) begin
                  err_r   <= 1'b0;
                  state_r <= ST_READ;
               end
            end
            default: state_r <= ST_READ;
         endcase
      end
   end

   // a fresh array reads erased; hence a plain always as its writer below
   initial begin
      for (int i = 0; i < WORDS; i++) mem[i] = `ERASED_WORD; // RULE_11
   end
   // array updates: program commit and erase sweep
   always @(posedge clk_sys_i) begin
      if (state_r == ST_PROG && op_r == OP_WORD && !err_r &&
          cnt_r == 32'(`PROGRAM_CYC - 1)) begin
         mem[prog_idx_r] <= prog_word_r;
      end else if (state_r == ST_ERASE && !sweep_done_r &&
                   emask_r[block_of({sweep_r, 2'b00})] &&
                   !(wr_i && wd == `CODE_SUSPEND)) begin
         mem[sweep_r] <= `ERASED_WORD;                 // RULE_11
      end
   end

   // status word while the controller works
   assign status_rd = (state_r == ST_PROG) || (state_r == ST_EWAIT) ||
                      (state_r == ST_ERASE) || (state_r == ST_FAIL) ||
                      (state_r == ST_SUSP && emask_r[block_of(addr_i)]);
   always_comb begin
      status = 16'h0000;
      status[`STAT_POLL_BIT] = (op_r == OP_WORD &&
                                (state_r == ST_PROG || state_r == ST_FAIL))
                               ? !prog_b7_r : (state_r == ST_SUSP); // RULE_26
      status[`STAT_TOGGLE_BIT]  = toggle_r;
      status[`STAT_ERROR_BIT]   = err_r;
      status[`STAT_ETO_BIT]     = (state_r != ST_EWAIT);
      status[`STAT_TOGGLE2_BIT] = toggle_r;
   end

   // toggle bits flip on each status read and on suspend or resume
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         toggle_r <= 1'b0;
      end else if ((rd_i && status_rd) ||
                   (wr_i && state_r == ST_ERASE && wd == `CODE_SUSPEND) ||
                   (wr_i && state_r == ST_SUSP && step_r == C_IDLE &&
                    wd == `CODE_RESUME)) begin
         toggle_r <= !toggle_r;                        // RULE_26
      end
   end

   // read data one cycle after the strobe, no wait states
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         rdata_o <= 32'h0;
      end else if (rd_i) begin                         // RULE_02
         if (state_r == ST_SETUP) begin
            rdata_o <= 32'h0;                          // RULE_19
         end else if (status_rd) begin
            rdata_o <= {status, status};               // RULE_13
         end else if (rprot_on && !fetch_i) begin
            rdata_o <= `READ_PROT_WORD;                // RULE_16
         end else begin
            // word index drops a1/a0; top bits pick the segment
            rdata_o <= mem[widx];                      // RULE_03 RULE_04
         end
      end
   end

   // cpu held in reset while setup runs and code boots from flash
   assign cpu_hold_o   = (state_r == ST_SETUP) && ea_sync_r[1]; // RULE_19
   assign busy_o       = (state_r == ST_PROG) || (state_r == ST_EWAIT) ||
                         (state_r == ST_ERASE);
   assign block_lock_o = lock_r;
   assign code_prot_o  = cprot_r;

endmodule

// file: test/flash_ctrl_monitor.sv
// port checker for the flash control block
`timescale 1ns/1ns
module flash_ctrl_monitor (
   input wire logic        clk_sys_i,
   input wire logic        rst_i,
   input wire logic        wr_i,
   input wire logic        rd_i,
   input wire logic        fetch_i,
   input wire logic [31:0] rdata_o,
   input wire logic        cpu_hold_o,
   input wire logic        busy_o,
   input wire logic [10:0] block_lock_o,
   input wire logic        code_prot_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   // reset itself must leave the port quiet, so it is not disabled here
   rst_quiet_a: assert property (disable iff (1'b0)
      rst_i |=> !busy_o && rdata_o == 32'h0) else $error("busy after reset");
   rdata_hold_a: assert property (!rd_i |=> $stable(rdata_o))
      else $error("read data moved without a read");
   busy_cause_a: assert property ($rose(busy_o) |-> $past(wr_i))
      else $error("busy without a command write");
   prot_read_a: assert property (rd_i && !fetch_i && code_prot_o &&
      !busy_o && !cpu_hold_o |=> rdata_o == 32'h009b009b)
      else $error("protected read leaked data");
   lock_keep_a: assert property (!$past(rst_i) |->
      ($past(block_lock_o) & ~block_lock_o) == 11'h0)
      else $error("lock bit cleared");
   setup_read_a: assert property (rd_i && cpu_hold_o |=>
      rdata_o == 32'h0) else $error("array readable during setup");
   status_dup_a: assert property (rd_i && busy_o |=>
      rdata_o[31:16] == rdata_o[15:0]) else $error("status halves differ");
   toggle_flip_a: assert property (rd_i && busy_o ##1 rd_i && busy_o
      |=> rdata_o[6] != $past(rdata_o[6])) else $error("toggle bit stuck");
   cover property ($fell(busy_o));
   cover property ($rose(block_lock_o[5]));
   cover property (rd_i && code_prot_o && !fetch_i);
endmodule

bind flash_ctrl flash_ctrl_monitor i_mon (.clk_sys_i(clk_sys_i),
   .rst_i(rst_i), .wr_i(wr_i), .rd_i(rd_i), .fetch_i(fetch_i),
   .rdata_o(rdata_o), .cpu_hold_o(cpu_hold_o), .busy_o(busy_o),
   .block_lock_o(block_lock_o), .code_prot_o(code_prot_o));

// file: test/cpu_model.sv
// cpu side model: array reads and command writes
`timescale 1ns/1ns
module cpu_model (
   input  wire logic        clk_sys_i,
   input  wire logic [31:0] rdata_i,
   output logic      [18:0] addr_o,
   output logic      [15:0] wdata_o,
   output logic             wr_o,
   output logic             rd_o,
   output logic             fetch_o
);
   initial begin
      addr_o = 19'h0;
      wdata_o = 16'h0;
      wr_o = 1'b0;
      rd_o = 1'b0;
      fetch_o = 1'b0;
   end
   // one write; commands run from code outside the flash
   task automatic wr(input logic [18:0] a, input logic [15:0] d);
      @(posedge clk_sys_i);
      addr_o <= a;
      wdata_o <= d;
      fetch_o <= 1'b0;
      wr_o <= 1'b1;
      @(posedge clk_sys_i);
      wr_o <= 1'b0;
      addr_o <= ~a; // released bus must not keep the old value
      wdata_o <= ~d;
      #1;
   endtask
   // two back-to-back reads, so the toggle bit is exercised
   task automatic rd(input logic [18:0] a, input logic f,
                     output logic [31:0] q0, output logic [31:0] q1);
      @(posedge clk_sys_i);
      addr_o <= a;
      fetch_o <= f;
      rd_o <= 1'b1;
      @(posedge clk_sys_i);
      #1 q0 = rdata_i;
      @(posedge clk_sys_i);
      rd_o <= 1'b0;
      addr_o <= ~a;
      #1 q1 = rdata_i;
   endtask
   task automatic unlock();
      wr(19'h01554, 16'h00a8);
      wr(19'h02aa8, 16'h0054);
   endtask
   task automatic cmd(input logic [15:0] c, input logic [18:0] a,
                      input logic [15:0] d);
      unlock();
      wr(19'h01554, c);
      wr(a, d);
   endtask
   task automatic erase(input logic [18:0] a);
      cmd(16'h0080, 19'h01554, 16'h00a8);
      wr(19'h02aa8, 16'h0054);
      wr(a, 16'h0030);
   endtask
endmodule

// file: test/flash_ctrl_tb.sv
// self-checking bench for the flash control block
`timescale 1ns/1ns
module flash_ctrl_tb;
   logic        clk_sys_i;
   logic        rst_i = 1'b1;
   logic        ea_n = 1'b1;
   logic        cpu_rst_n = 1'b1;
   logic [18:0] addr;
   logic [15:0] wdata;
   logic        wr, rd, fetch, hold, busy, cprot;
   logic [31:0] rdata, q0, q1;
   logic [10:0] lock;
   int          n_errors = 0;
   int          n_compared = 0;

   // short erase pulse keeps the run brief
   flash_ctrl #(.ERASE_CYC(32'd200)) i_dut (.clk_sys_i(clk_sys_i),
      .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
      .fetch_i(fetch), .rdata_o(rdata), .external_access_pin_n_i(ea_n),
      .cpu_reset_n_i(cpu_rst_n), .cpu_hold_o(hold), .busy_o(busy),
      .block_lock_o(lock), .code_prot_o(cprot));
   cpu_model i_cpu (.clk_sys_i(clk_sys_i), .rdata_i(rdata), .addr_o(addr),
      .wdata_o(wdata), .wr_o(wr), .rd_o(rd), .fetch_o(fetch));

   initial begin
      clk_sys_i = 1'b0;
      forever #25 clk_sys_i = ~clk_sys_i;
   end
   task automatic chk(input string nm, input logic [31:0] e, s);
      n_compared++;
      if (s !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic wait_idle();
      for (int k = 0; k < 400 && busy !== 1'b0; k++)
         @(posedge clk_sys_i);
      #1 chk("busy end", 0, 32'(busy));
   endtask
   task automatic conclude();
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // power-on setup hides the array and holds the cpu
   task automatic t_setup();
      repeat (4) @(posedge clk_sys_i);
      chk("hold", 1, 32'(hold));
      i_cpu.rd(19'h0, 1'b1, q0, q1);
      chk("setup rd", 0, q0);
      repeat (420) @(posedge clk_sys_i);
      #1 chk("hold off", 0, 32'(hold));
   endtask
   // word program with a pause, status, then a 1-over-0 error
   task automatic t_prog();
      i_cpu.unlock();
      repeat (50) @(posedge clk_sys_i);
      i_cpu.wr(19'h01554, 16'h00a0);
      chk("early", 0, 32'(busy));
      i_cpu.wr(19'h20010, 16'h1234);
      chk("busy", 1, 32'(busy));
      i_cpu.rd(19'h20010, 1'b0, q0, q1);
      chk("poll", 1, 32'(q0[7]));
      wait_idle();
      i_cpu.cmd(16'h00a0, 19'h20012, 16'h5678);
      wait_idle();
      i_cpu.rd(19'h20013, 1'b0, q0, q1);
      chk("word", 32'h56781234, q0);
      i_cpu.cmd(16'h00a0, 19'h20010, 16'hffff);
      wait_idle();
      i_cpu.rd(19'h20010, 1'b0, q0, q1);
      chk("err", 1, 32'(q0[5]));
      i_cpu.wr(19'h01554, 16'h00f0);
      i_cpu.rd(19'h30010, 1'b0, q0, q1);
      chk("seg", 32'hffffffff, q0);
   endtask
   // broken sequence falls back to read mode
   task automatic t_bad();
      i_cpu.wr(19'h01554, 16'h00a8);
      i_cpu.wr(19'h02aa0, 16'h0054);
      i_cpu.wr(19'h01554, 16'h00a0);
      i_cpu.wr(19'h20020, 16'h0000);
      chk("bad", 0, 32'(busy));
   endtask
   // lock, refused program, temporary unlock
   task automatic t_lock();
      i_cpu.cmd(16'h00c0, 19'h20000, 16'h00c0);
      wait_idle();
      chk("lock", 32'h20, 32'(lock));
      i_cpu.cmd(16'h00a0, 19'h20020, 16'h0000);
      chk("refuse", 0, 32'(busy));
      i_cpu.cmd(16'h00c1, 19'h20000, 16'h00c1);
      wait_idle();
      chk("kept", 32'h20, 32'(lock));
      i_cpu.cmd(16'h00a0, 19'h20020, 16'h0000);
      wait_idle();
      i_cpu.rd(19'h20020, 1'b0, q0, q1);
      chk("unlock", 32'hffff0000, q0);
   endtask
   // time-out restart, abort, suspend and resume, cpu reset
   task automatic t_erase();
      i_cpu.erase(19'h30000);
      i_cpu.wr(19'h20000, 16'h0000);
      chk("abort", 0, 32'(busy));
      i_cpu.erase(19'h30000);
      repeat (1500) @(posedge clk_sys_i);
      i_cpu.wr(19'h40000, 16'h0030);
      repeat (1500) @(posedge clk_sys_i);
      i_cpu.rd(19'h30000, 1'b0, q0, q1);
      chk("restart", 0, 32'(q0[3]));
      repeat (500) @(posedge clk_sys_i);
      i_cpu.rd(19'h30000, 1'b0, q0, q1);
      chk("started", 32'h9, {28'h0, q0[3], 2'h0, busy});
      i_cpu.wr(19'h30000, 16'h00b0);
      chk("susp", 0, 32'(busy));
      i_cpu.rd(19'h20020, 1'b0, q0, q1);
      chk("other", 32'hffff0000, q0);
      i_cpu.wr(19'h30000, 16'h0030);
      chk("resume", 1, 32'(busy));
      @(posedge clk_sys_i) cpu_rst_n <= 1'b0;
      repeat (50) @(posedge clk_sys_i);
      cpu_rst_n <= 1'b1;
      repeat (5) @(posedge clk_sys_i);
      #1 chk("cpurst", 32'h20, {busy, 20'h0, lock});
      i_cpu.cmd(16'h00a0, 19'h20024, 16'h0000);
      chk("relock", 0, 32'(busy));
   endtask
   // read protection spares instruction fetches only
   task automatic t_cprot();
      i_cpu.cmd(16'h00c2, 19'h00000, 16'h00c2);
      wait_idle();
      chk("cprot", 1, 32'(cprot));
      i_cpu.rd(19'h20020, 1'b0, q0, q1);
      chk("prot", 32'h009b009b, q0);
      i_cpu.rd(19'h20020, 1'b1, q0, q1);
      chk("fetch", 32'hffff0000, q0);
   endtask

   initial begin
      repeat (4) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      t_setup();
      t_prog();
      t_bad();
      t_lock();
      t_erase();
      t_cprot();
      conclude();
   end
   // watchdog: the whole run needs well under 20000 cycles
   initial begin
      #(20000 * 50);
      n_errors++;
      conclude();
   end
endmodule
